/* rtl/burst_sram_pkg.sv */
/*
 * Shared constants of the four-word burst SRAM port logic: array geometry,
 * word and byte-lane layout, and the length of the single-clock strap window.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package burst_sram_pkg;
    // geometry: 4 words of 18 bits per location, 512K locations
    localparam int ADDR_W = 19;
    localparam int WORD_W = 18;
    localparam int BURST_LEN = 4;
    localparam int LINE_W = WORD_W * BURST_LEN;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int LINE_LANES = LANES * BURST_LEN;
    localparam int DEPTH = 1 << ADDR_W;
    // bit offset of each word inside a stored 72-bit line, lowest word first
    localparam int WORD0_LSB = 0;
    localparam int WORD1_LSB = WORD_W;
    localparam int WORD2_LSB = 2 * WORD_W;
    localparam int WORD3_LSB = 3 * WORD_W;
    // reset values
    localparam logic RST_OE_N = 1'b1;
    localparam logic RST_SINGLE = 1'b1;
    localparam logic [WORD_W-1:0] RST_WORD = 18'h00000;
    localparam logic [ADDR_W-1:0] RST_ADDR = 19'h00000;
    // system-clock cycles over which the output clock strap is watched
    localparam int STRAP_CNT_W = 4;
    localparam logic [STRAP_CNT_W-1:0] STRAP_WIN = 4'hf;
    localparam logic [STRAP_CNT_W-1:0] STRAP_CNT_RST = 4'h0;
endpackage : burst_sram_pkg

/* rtl/burst_sram_ports.sv */
/*
 * Port logic of a synchronous pipelined burst SRAM with a separate read
 * port and write port sharing one address bus, four 18-bit words per
 * access moved on both edges of the clocks. The link clock i_k_clk is the
 * positive input clock; its falling edge stands for the rise of the
 * negative input clock. Read data leaves on both edges of the output clock
 * i_c_clk, or of i_k_clk in single clock mode. The output clock is taken to
 * be frequency-locked to i_k_clk with small skew, as the memory bus needs.
 * i_clk carries only the strap watch and status back to the system.
 */
`timescale 1ns/1ps
`default_nettype none


module burst_sram_ports
    import burst_sram_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_k_clk,
    input wire logic i_c_clk,
    input wire logic i_c_n_clk,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_read_port_sel_n,
    input wire logic i_write_port_sel_n,
    input wire logic [LANES-1:0] i_byte_lane_wr_sel_n,
    input wire logic [WORD_W-1:0] i_wdata,
    output logic [WORD_W-1:0] o_rdata,
    output logic o_rdata_oe_n,
    output logic o_single_mode,
    output logic o_rd_active,
    output logic o_wr_active
);

    ////////////////////////////////////////////////////////////////////////
    // system domain: output clock strap watch

    logic [1:0] strap_meta_q;
    logic [1:0] strap_sync_q;
    logic [STRAP_CNT_W-1:0] strap_cnt_q;
    logic single_q;

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            // held high so a strapped part is not taken for a running one
            strap_meta_q <= {2{RST_SINGLE}};
            strap_sync_q <= {2{RST_SINGLE}};
        end
        else if (i_ce)
        begin
            // each clock pin synchronised on its own before they are combined
            strap_meta_q <= {i_c_n_clk, i_c_clk};
            strap_sync_q <= strap_meta_q;
        end
    end

    // both output clocks must stay high for the whole window
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            strap_cnt_q <= STRAP_CNT_RST;
            single_q <= RST_SINGLE;
        end
        else if (i_ce && strap_cnt_q != STRAP_WIN)
        begin
            strap_cnt_q <= strap_cnt_q + 4'h1;
            if (strap_sync_q != 2'h3)
            begin
                single_q <= 1'b0;
            end
        end
    end

    assign o_single_mode = single_q;

    ////////////////////////////////////////////////////////////////////////
    // link domain: strap level brought over; it is static after the window

    logic single_meta_q;
    logic single_k_q;

    always_ff @(posedge i_k_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            single_meta_q <= RST_SINGLE;
            single_k_q <= RST_SINGLE;
        end
        else
        begin
            single_meta_q <= single_q;
            single_k_q <= single_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request sampling and arbitration at the positive input clock rise

    logic rd_prev_q;
    logic wr_prev_q;
    logic rd_go;
    logic wr_go;

    // a port just started cannot start again; read wins unless it just ran
    assign rd_go = !i_read_port_sel_n && !rd_prev_q;
    assign wr_go = !i_write_port_sel_n && !wr_prev_q && !rd_go;

    always_ff @(posedge i_k_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end
        else
        begin
            rd_prev_q <= rd_go;
            wr_prev_q <= wr_go;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory array, no reset: contents are undefined at power-up

    logic [LINE_W-1:0] mem_q [0:DEPTH-1];

    ////////////////////////////////////////////////////////////////////////
    // read path

    logic [ADDR_W-1:0] raddr_q;
    logic [LINE_W-1:0] rd_line_q;
    logic [WORD_W-1:0] rd_last_q;
    logic rd_ph1_q;
    logic rd_ph2_q;

    always_ff @(posedge i_k_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            raddr_q <= RST_ADDR;
        end
        else if (rd_go)
        begin
            raddr_q <= i_addr;
        end
    end

    // ph1: cycle after rd_prev_q, ph2: the one after that
    always_ff @(posedge i_k_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rd_ph1_q <= 1'b0;
            rd_ph2_q <= 1'b0;
        end
        else
        begin
            rd_ph1_q <= rd_prev_q;
            rd_ph2_q <= rd_ph1_q;
        end
    end

    // the last word is parked so a following read may reload the line
    always_ff @(posedge i_k_clk)
    begin
        if (rd_prev_q)
        begin
            rd_line_q <= mem_q[raddr_q];
        end
        if (rd_ph1_q)
        begin
            rd_last_q <= rd_line_q[WORD3_LSB +: WORD_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output registers on both edges of the output clock

    logic out_clk;
    logic [WORD_W-1:0] q_pos_q;
    logic [WORD_W-1:0] q_neg_q;
    logic oe_pos_n_q;
    logic oe_neg_n_q;

    // static select: the strap never changes once the window has closed
    assign out_clk = single_k_q ? i_k_clk : i_c_clk;

    always_ff @(posedge out_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            q_pos_q <= RST_WORD;
            oe_pos_n_q <= RST_OE_N;
        end
        else
        begin
            q_pos_q <= rd_ph1_q ? rd_line_q[WORD1_LSB +: WORD_W] : rd_last_q;
            oe_pos_n_q <= !(rd_ph1_q || rd_ph2_q);
        end
    end

    always_ff @(negedge out_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            q_neg_q <= RST_WORD;
            oe_neg_n_q <= RST_OE_N;
        end
        else
        begin
            q_neg_q <= rd_ph1_q ? rd_line_q[WORD0_LSB +: WORD_W]
                                : rd_line_q[WORD2_LSB +: WORD_W];
            oe_neg_n_q <= !(rd_ph1_q || rd_ph2_q);
        end
    end

    // the clock level picks whichever edge register fired last
    assign o_rdata = out_clk ? q_pos_q : q_neg_q;
    assign o_rdata_oe_n = out_clk ? oe_pos_n_q : oe_neg_n_q;

    ////////////////////////////////////////////////////////////////////////
    // write path: words 0 and 2 on the rise, 1 and 3 on the fall

    logic [ADDR_W-1:0] waddr_q;
    logic [ADDR_W-1:0] cm_addr_q;
    logic wb1_q;
    logic wb2_q;
    logic [WORD_W-1:0] wd0_q;
    logic [WORD_W-1:0] wd1_q;
    logic [WORD_W-1:0] wd2_q;
    logic [WORD_W-1:0] wd3_q;
    logic [LANES-1:0] be0_n_q;
    logic [LANES-1:0] be1_n_q;
    logic [LANES-1:0] be2_n_q;
    logic [LANES-1:0] be3_n_q;

    always_ff @(posedge i_k_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            waddr_q <= RST_ADDR;
            cm_addr_q <= RST_ADDR;
        end
        else
        begin
            if (wr_go)
            begin
                waddr_q <= i_addr;
            end
            // a new write may reload waddr on this edge, so move it on
            if (wb1_q)
            begin
                cm_addr_q <= waddr_q;
            end
        end
    end

    always_ff @(posedge i_k_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wb1_q <= 1'b0;
            wb2_q <= 1'b0;
        end
        else
        begin
            wb1_q <= wr_prev_q;
            wb2_q <= wb1_q;
        end
    end

    // data is taken only inside a burst; outside it inputs are ignored
    always_ff @(posedge i_k_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wd0_q <= RST_WORD;
            wd2_q <= RST_WORD;
            be0_n_q <= '1;
            be2_n_q <= '1;
        end
        else if (wr_prev_q)
        begin
            wd0_q <= i_wdata;
            be0_n_q <= i_byte_lane_wr_sel_n;
        end
        else if (wb1_q)
        begin
            wd2_q <= i_wdata;
            be2_n_q <= i_byte_lane_wr_sel_n;
        end
    end

    always_ff @(negedge i_k_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wd1_q <= RST_WORD;
            wd3_q <= RST_WORD;
            be1_n_q <= '1;
            be3_n_q <= '1;
        end
        else if (wb1_q)
        begin
            wd1_q <= i_wdata;
            be1_n_q <= i_byte_lane_wr_sel_n;
        end
        else if (wb2_q)
        begin
            wd3_q <= i_wdata;
            be3_n_q <= i_byte_lane_wr_sel_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte-lane merge and commit

    logic [LINE_W-1:0] wr_line;
    logic [LINE_LANES-1:0] wr_be_n;
    logic [LINE_W-1:0] old_line;
    logic [LINE_W-1:0] new_line;

    assign wr_line = {wd3_q, wd2_q, wd1_q, wd0_q};
    assign wr_be_n = {be3_n_q, be2_n_q, be1_n_q, be0_n_q};
    assign old_line = mem_q[cm_addr_q];

    genvar lane;
    generate
        for (lane = 0; lane < LINE_LANES; lane++)
        begin : g_lane
            assign new_line[lane*LANE_W +: LANE_W] = wr_be_n[lane]
                ? old_line[lane*LANE_W +: LANE_W]
                : wr_line[lane*LANE_W +: LANE_W];
        end
    endgenerate

    // read of a line being committed on the same edge sees the old line
    always_ff @(posedge i_k_clk)
    begin
        if (wb2_q)
        begin
            mem_q[cm_addr_q] <= new_line;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // activity back to the system domain as synchronised levels

    logic rd_busy_k_q;
    logic wr_busy_k_q;
    logic [1:0] rd_busy_sync_q;
    logic [1:0] wr_busy_sync_q;

    always_ff @(posedge i_k_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rd_busy_k_q <= 1'b0;
            wr_busy_k_q <= 1'b0;
        end
        else
        begin
            rd_busy_k_q <= rd_go || rd_prev_q || rd_ph1_q;
            wr_busy_k_q <= wr_go || wr_prev_q || wb1_q || wb2_q;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rd_busy_sync_q <= 2'h0;
            wr_busy_sync_q <= 2'h0;
        end
        else if (i_ce)
        begin
            rd_busy_sync_q <= {rd_busy_sync_q[0], rd_busy_k_q};
            wr_busy_sync_q <= {wr_busy_sync_q[0], wr_busy_k_q};
        end
    end

    assign o_rd_active = rd_busy_sync_q[1];
    assign o_wr_active = wr_busy_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // checks in the link and output clock domains

    sequence rd_phases_s;
        rd_prev_q ##1 rd_ph1_q ##1 rd_ph2_q;
    endsequence

    sequence wr_beats_s;
        wr_prev_q ##1 wb1_q ##1 wb2_q;
    endsequence

    AST_RD_SPACING: assert property (@(posedge i_k_clk) disable iff (i_sys_rst)
        rd_go |=> !rd_go)
        else $error("read started on two consecutive rises");

    AST_WR_SPACING: assert property (@(posedge i_k_clk) disable iff (i_sys_rst)
        wr_go |=> !wr_go)
        else $error("write started on two consecutive rises");

    AST_ONE_START: assert property (@(posedge i_k_clk) disable iff (i_sys_rst)
        !(rd_go && wr_go))
        else $error("read and write started on the same rise");

    AST_ARB_ALTERNATE: assert property (@(posedge i_k_clk) disable iff (i_sys_rst)
        (!i_read_port_sel_n && !i_write_port_sel_n) |-> ($past(rd_go) ? wr_go : rd_go))
        else $error("both selected but wrong port started");

    AST_RD_PIPE: assert property (@(posedge i_k_clk) disable iff (i_sys_rst)
        rd_go |=> rd_phases_s)
        else $error("read burst phases out of step");

    AST_WR_PIPE: assert property (@(posedge i_k_clk) disable iff (i_sys_rst)
        wr_go |=> wr_beats_s)
        else $error("write beat phases out of step");

    AST_RADDR_CAPTURE: assert property (@(posedge i_k_clk) disable iff (i_sys_rst)
        rd_go |=> raddr_q == $past(i_addr))
        else $error("read address not captured with request");

    AST_WADDR_COMMIT: assert property (@(posedge i_k_clk) disable iff (i_sys_rst)
        wr_go |=> ##2 cm_addr_q == $past(i_addr, 3))
        else $error("commit address differs from write request address");

    AST_OUT_FLOAT: assert property (@(posedge out_clk) disable iff (i_sys_rst)
        (!rd_ph1_q && !rd_ph2_q) |=> oe_pos_n_q)
        else $error("read outputs driven with no read pending");

endmodule : burst_sram_ports

`default_nettype wire

/* sim/sram_ctrl_model.sv */
/*
 * Memory controller model: makes the input and output clocks and plays
 * queued commands onto the select, address, lane select and data pins.
 * Assumes the testbench queues commands through issue() and polls pending().
 */
`timescale 1ns/1ps
`default_nettype none

module sram_ctrl_model
    import burst_sram_pkg::*;
(
    output logic o_k_clk,
    output logic o_c_clk,
    output logic o_c_n_clk,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_read_port_sel_n,
    output logic o_write_port_sel_n,
    output logic [LANES-1:0] o_byte_lane_wr_sel_n,
    output logic [WORD_W-1:0] o_wdata,
    input wire logic i_strap_single
);
    localparam int CMD_W = 3 + ADDR_W + LINE_W + LINE_LANES;
    logic [CMD_W-1:0] cmd_q[$];
    logic [LANES+WORD_W-1:0] beat_q[$];
    logic [CMD_W-1:0] cmd;
    logic data_due_q;
    logic [LINE_W-1:0] line_q;
    logic [LINE_LANES-1:0] be_q;
    int i;

    task automatic issue(input logic [2:0] kind, input logic [ADDR_W-1:0] a,
        input logic [LINE_W-1:0] line, input logic [LINE_LANES-1:0] be_n);
        cmd_q.push_back({kind, a, line, be_n});
    endtask : issue

    function automatic int pending();
        return cmd_q.size() + beat_q.size();
    endfunction : pending

    initial
    begin
        o_k_clk = 1'b0;
        #37;
        forever #80 o_k_clk = ~o_k_clk;
    end

    // output clocks locked to the input clock, or both held high as the strap
    assign o_c_clk = i_strap_single ? 1'b1 : o_k_clk;
    assign o_c_n_clk = i_strap_single ? 1'b1 : ~o_k_clk;

    initial
    begin
        o_addr = 19'h00000;
        o_read_port_sel_n = 1'b1;
        o_write_port_sel_n = 1'b1;
        o_byte_lane_wr_sel_n = 2'h3;
        o_wdata = 18'h00000;
        data_due_q = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // pop before push: a new burst follows the last beat of the previous one
    always @(posedge o_k_clk or negedge o_k_clk)
    begin
        if (beat_q.size() != 0)
            {o_byte_lane_wr_sel_n, o_wdata} <= beat_q.pop_front();
        else
            {o_byte_lane_wr_sel_n, o_wdata} <= ~{o_byte_lane_wr_sel_n, o_wdata};
        if (o_k_clk)
        begin
            if (data_due_q)
                for (i = 0; i < BURST_LEN; i++)
                    beat_q.push_back({be_q[i*LANES +: LANES], line_q[i*WORD_W +: WORD_W]});
            if (cmd_q.size() != 0)
                cmd = cmd_q.pop_front();
            else
                cmd = '0;
            o_read_port_sel_n <= ~cmd[CMD_W-3];
            o_write_port_sel_n <= ~cmd[CMD_W-2];
            // one shared address bus; garbage when nothing is selected
            if (cmd[CMD_W-2 -: 2] != 2'h0)
                o_addr <= cmd[LINE_W+LINE_LANES +: ADDR_W];
            else
                o_addr <= ~o_addr;
            data_due_q <= cmd[CMD_W-1];
            line_q <= cmd[LINE_LANES +: LINE_W];
            be_q <= cmd[LINE_LANES-1:0];
        end
    end
endmodule : sram_ctrl_model

`default_nettype wire

/* sim/test_quad_rate_sram_burst4_ports.sv */
/*
 * Self-checking bench of the burst SRAM port logic against a controller
 * model; read words are noted in a queue and compared as they leave.
 * Assumes the output clock equals the input clock in frequency and phase.
 */
`timescale 1ns/1ps
`default_nettype none

module test_quad_rate_sram_burst4_ports
    import burst_sram_pkg::*;
;
    localparam logic [2:0] IDLE = 3'h0;
    localparam logic [2:0] RD = 3'h1;
    localparam logic [2:0] WR_NODATA = 3'h2;
    localparam logic [2:0] BOTH = 3'h3;
    localparam logic [2:0] WR = 3'h6;
    localparam logic [2:0] BOTH_DATA = 3'h7;
    logic i_clk, i_sys_rst, i_ce, k_clk, c_clk, c_n_clk, rsel_n, wsel_n, o_rdata_oe_n;
    logic o_single_mode, o_rd_active, o_wr_active, on_q;
    logic [ADDR_W-1:0] addr, a0, a1, a2;
    logic [LANES-1:0] be_n;
    logic [WORD_W-1:0] wdata, o_rdata;
    logic [WORD_W-1:0] exp_q[$];
    logic [LINE_W-1:0] mem [int];
    int miscompares = 0, checked = 0, cycles = 0, seed_v, j;
    int rd_act_cnt = 0, wr_act_cnt = 0, act_snap;
    logic strap;

    sram_ctrl_model ctrl_u (.o_k_clk(k_clk), .o_c_clk(c_clk), .o_c_n_clk(c_n_clk),
        .o_addr(addr), .o_read_port_sel_n(rsel_n), .o_write_port_sel_n(wsel_n),
        .o_byte_lane_wr_sel_n(be_n), .o_wdata(wdata), .i_strap_single(strap));
    burst_sram_ports dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .i_k_clk(k_clk), .i_c_clk(c_clk), .i_c_n_clk(c_n_clk), .i_addr(addr),
        .i_read_port_sel_n(rsel_n), .i_write_port_sel_n(wsel_n),
        .i_byte_lane_wr_sel_n(be_n), .i_wdata(wdata), .o_rdata(o_rdata),
        .o_rdata_oe_n(o_rdata_oe_n), .o_single_mode(o_single_mode),
        .o_rd_active(o_rd_active), .o_wr_active(o_wr_active));

    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    task automatic check(input string name, input logic [WORD_W-1:0] exp,
        input logic [WORD_W-1:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    function automatic logic [LINE_W-1:0] rnd_line();
        return LINE_W'({$urandom, $urandom, $urandom});
    endfunction : rnd_line

    task automatic wr(input logic [2:0] kind, input logic [ADDR_W-1:0] a,
        input logic [LINE_W-1:0] line, input logic [LINE_LANES-1:0] be);
        int k;
        ctrl_u.issue(kind, a, line, be);
        if (!mem.exists(a))
            mem[a] = '0;
        for (k = 0; k < LINE_LANES; k++)
            if (!be[k])
                mem[a][k*LANE_W +: LANE_W] = line[k*LANE_W +: LANE_W];
    endtask : wr

    task automatic rd(input logic [2:0] kind, input logic [ADDR_W-1:0] a);
        int k;
        ctrl_u.issue(kind, a, '0, '1);
        for (k = 0; k < BURST_LEN; k++)
            exp_q.push_back(mem[a][k*WORD_W +: WORD_W]);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) ctrl_u.issue(IDLE, '0, '0, '1);
    endtask : idle

    // bursts still in flight when the queue empties get a fixed margin
    task automatic drain();
        while (ctrl_u.pending() != 0)
            @(posedge i_clk);
        repeat (64) @(posedge i_clk);
        check("words left", WORD_W'(0), WORD_W'(exp_q.size()));
        check("oe_n idle", WORD_W'(1), WORD_W'(o_rdata_oe_n));
        check("rd active idle", WORD_W'(0), WORD_W'(o_rd_active));
        check("wr active idle", WORD_W'(0), WORD_W'(o_wr_active));
    endtask : drain

    ////////////////////////////////////////////////////////////////////////
    // sample mid half-cycle, where the launched word has settled
    initial
        on_q = 1'b0;
    // timed from the input clock: strapped output clocks stand still
    always @(posedge k_clk or negedge k_clk)
    begin
        #40;
        if (o_rdata_oe_n === 1'b0)
        begin
            if (exp_q.size() == 0)
            begin
                miscompares++;
                $display("[FAIL] rdata expected none seen %h", o_rdata);
            end
            else
                check("rdata", exp_q.pop_front(), o_rdata);
            on_q = 1'b1;
        end
        else
        begin
            if (on_q && exp_q.size() != 0)
                check("rdata gap", WORD_W'(0), WORD_W'(1));
            on_q = 1'b0;
        end
    end

    always @(posedge i_clk)
    begin
        cycles++;
        if (o_rd_active === 1'b1)
            rd_act_cnt++;
        if (o_wr_active === 1'b1)
            wr_act_cnt++;
        if (cycles == 30000)
        begin
            miscompares++;
            results();
        end
    end

    initial
    begin
        i_sys_rst = 1'b1;
        i_ce = 1'b0;
        strap = 1'b0;
        seed_v = $urandom(84484);
        repeat (6) @(posedge k_clk);
        @(posedge i_clk);
        check("oe_n reset", WORD_W'(1), WORD_W'(o_rdata_oe_n));
        check("rdata reset", RST_WORD, o_rdata);
        i_sys_rst <= 1'b0;
        i_ce <= 1'b1;
        repeat (40) @(posedge i_clk);
        check("single mode", WORD_W'(0), WORD_W'(o_single_mode));
        $display("test reset done");
        a0 = ADDR_W'($urandom);
        a1 = a0 + 19'h00001;
        a2 = a0 + 19'h00002;
        wr(WR, a0, rnd_line(), '0);
        idle(1);
        wr(WR, a1, rnd_line(), '0);
        idle(4);
        drain();
        check("wr active seen", WORD_W'(1), WORD_W'(wr_act_cnt != 0));
        rd(RD, a0);
        idle(1);
        rd(RD, a1);
        drain();
        check("rd active seen", WORD_W'(1), WORD_W'(rd_act_cnt != 0));
        $display("test stream done");
        for (j = 0; j < 2; j++)
        begin
            wr(WR, a0, rnd_line(), (j == 0) ? LINE_LANES'($urandom) : {LINE_LANES{1'b1}});
            idle(4);
            drain();
            rd(RD, a0);
            drain();
        end
        $display("test lanes done");
        wr(WR, a1, rnd_line(), '0);
        ctrl_u.issue(WR_NODATA, a0, '0, '1);
        idle(4);
        drain();
        rd(RD, a1);
        ctrl_u.issue(RD, a0, '0, '1);
        idle(4);
        drain();
        rd(RD, a0);
        drain();
        $display("test refusal done");
        rd(BOTH, a0);
        wr(BOTH_DATA, a2, rnd_line(), '0);
        idle(4);
        drain();
        rd(RD, a2);
        drain();
        $display("test arbitration done");
        // second reset with both output clocks strapped high
        strap <= 1'b1;
        i_sys_rst <= 1'b1;
        repeat (6) @(posedge k_clk);
        @(posedge i_clk);
        check("oe_n reset again", WORD_W'(1), WORD_W'(o_rdata_oe_n));
        check("rdata reset again", RST_WORD, o_rdata);
        i_sys_rst <= 1'b0;
        repeat (40) @(posedge i_clk);
        check("single mode strapped", WORD_W'(1), WORD_W'(o_single_mode));
        // link side keeps working while the system side is frozen
        act_snap = wr_act_cnt;
        i_ce <= 1'b0;
        wr(WR, a2, rnd_line(), '0);
        idle(4);
        drain();
        check("wr active frozen", WORD_W'(act_snap), WORD_W'(wr_act_cnt));
        i_ce <= 1'b1;
        rd(RD, a2);
        idle(1);
        rd(RD, a1);
        drain();
        $display("test single clock done");
        results();
    end
endmodule : test_quad_rate_sram_burst4_ports

`default_nettype wire
